// *** rtl/pmv_defines.vh ***
`ifndef PMV_DEFINES_VH
`define PMV_DEFINES_VH

// ******************************************************
// Register select values within one transceiver
// ******************************************************
`define PMV_REG_LINE_CONTROL 5'h00
`define PMV_REG_LINE_STATUS 5'h01
`define PMV_REG_IDENT_HIGH 5'h02
`define PMV_REG_IDENT_LOW 5'h03
`define PMV_REG_NEG_OFFER 5'h04
`define PMV_REG_PARTNER_ABIL 5'h05

// ******************************************************
// Management frame constants
// ******************************************************
`define PMV_PREAMBLE_ONES 6'h20
`define PMV_OP_WRITE 2'h1
`define PMV_OP_READ 2'h2
`define PMV_HDR_BITS 4'hC
`define PMV_DATA_BITS 5'h10
`define PMV_SKIP_BITS 5'h12

// ******************************************************
// Control word fields (management view)
// ******************************************************
`define PMV_CTL_MDIX_OFF 3
`define PMV_CTL_FEF_OFF 2
`define PMV_CTL_TX_OFF 1
`define PMV_CTL_IND_OFF 0
`define PMV_CTL_RESET 4'h0

// ******************************************************
// Control byte fields (per-port switch view, regs 29/45)
// ******************************************************
`define PMV_SW_MDIX_OFF 2
`define PMV_SW_FEF_OFF 4
`define PMV_SW_TX_OFF 6
`define PMV_SW_IND_OFF 7

// ******************************************************
// Status word fields
// ******************************************************
`define PMV_STS_ABILITY 4'hF
`define PMV_STS_AN_DONE 5
`define PMV_STS_FEF 4
`define PMV_STS_AN_CAP 3
`define PMV_STS_LINK 2

// ******************************************************
// Offer word fields; switch view (regs 28/44) uses bits 4..0 and 7
// ******************************************************
`define PMV_ADV_PAUSE 10
`define PMV_ADV_100F 8
`define PMV_ADV_100H 7
`define PMV_ADV_10F 6
`define PMV_ADV_10H 5
`define PMV_ADV_SELECTOR 5'h01
`define PMV_ADV_RESET 6'h3F
`define PMV_SW_AN_EN 7

`endif

// *** rtl/pmv_mdc_sense.v ***
`timescale 1ns/1ps
`default_nettype none

// Rising-edge detector on the management clock, one-cycle enable out
module pmv_mdc_sense (
   input wire clk_sys,
   input wire rst_n,
   input wire mdc,
   output wire mdc_rise
);

   reg mdc_q;

   // Previous level of the management clock
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc;
      end
   end

   assign mdc_rise = mdc & ~mdc_q;

endmodule // pmv_mdc_sense

`default_nettype wire

// *** rtl/pmv_ctrl_mirror.v ***
`timescale 1ns/1ps
`default_nettype none

// One set of control bits written from two paths, so both views agree
module pmv_ctrl_mirror #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk_sys,
   input wire rst_n,
   input wire mii_wr,
   input wire [WIDTH-1:0] mii_mask,
   input wire [WIDTH-1:0] mii_data,
   input wire sw_wr,
   input wire [WIDTH-1:0] sw_mask,
   input wire [WIDTH-1:0] sw_data,
   output wire [WIDTH-1:0] bits
);

   reg [WIDTH-1:0] bits_q;

   // Per-bit update; switch path is tested first so it wins a same-cycle clash
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk_sys) begin
            if (!rst_n) begin
               bits_q[i] <= RESET_VAL[i];
            end else if (sw_wr && sw_mask[i]) begin
               bits_q[i] <= sw_data[i];
            end else if (mii_wr && mii_mask[i]) begin
               bits_q[i] <= mii_data[i];
            end
         end
      end
   endgenerate

   assign bits = bits_q;

endmodule // pmv_ctrl_mirror

`default_nettype wire

// *** rtl/pmv_phy_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pmv_defines.vh"

//Operation
//- Control bit 3 set disables automatic crossover; read/write, resets zero.
//- Control bit 2 set stops far-end fault detection; resets zero.
//- Control bit 1 set stops line transmission; resets zero.
//- Control bit 0 set turns indicator outputs off; resets zero.
//- Control fields mirror per-port switch control bits; either path seen by both.
//- Status four-pair capability bit always reads zero.
//- Status speed/duplex capability bits always read one.
//- Status bit 0, bits 10..7 and bit 6 read zero.
//- Status bit 5 shows negotiation complete; resets zero.
//- Status bit 4 shows far-end fault detected; resets zero.
//- Status bit 3 shows negotiation capability, mirrors enable, default one.
//- Status bit 2 shows link up; resets zero.
//- Register 2 returns fixed upper identifier word.
//- Register 3 returns fixed lower identifier word.
//- Offer bit 10 pause, read/write, resets one.
//- Offer bit 8 100 full duplex, read/write, resets one.
//- Offer bit 7 100 half duplex, read/write, resets one.
//- Offer bit 6 10 full duplex, read/write, resets one.
//- Offer bit 5 10 half duplex, read/write, resets one.
module pmv_phy_regs #(
   parameter [4:0] PHY_ADDR = 5'h01,
   parameter [15:0] IDENT_UPPER = 16'h1234, // Arbitrary value
   parameter [15:0] IDENT_LOWER = 16'h5678 // Arbitrary value
) (
   input wire clk_sys,
   input wire rst_n,
   input wire mdc,
   input wire mdio_in,
   output reg mdio_out,
   output reg mdio_oe,
   input wire sw_ctrl_wr,
   input wire [7:0] sw_ctrl_wdata,
   output wire [7:0] sw_ctrl_rdata,
   input wire sw_adv_wr,
   input wire [7:0] sw_adv_wdata,
   output wire [7:0] sw_adv_rdata,
   input wire negotiation_done,
   input wire link_up,
   input wire far_end_fault,
   input wire [4:0] partner_bits,
   input wire [2:0] indicator_raw,
   output reg [2:0] indicator_out,
   output wire mdix_off,
   output wire fef_detect_off,
   output wire tx_off,
   output wire indicator_off,
   output wire an_enable,
   output wire [4:0] offer_bits
);

   // ******************************************************
   // Frame receiver states
   // ******************************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_HDR = 3'h2;
   localparam [2:0] ST_RD_TA = 3'h3;
   localparam [2:0] ST_RD_DATA = 3'h4;
   localparam [2:0] ST_WR_TA = 3'h5;
   localparam [2:0] ST_WR_DATA = 3'h6;
   localparam [2:0] ST_SKIP = 3'h7;

   wire mdc_rise;
   wire [3:0] ctrl_bits;
   wire [5:0] adv_bits;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [5:0] pre_cnt_q;
   reg [5:0] pre_cnt_d;
   reg [4:0] bit_cnt_q;
   reg [4:0] bit_cnt_d;
   reg [11:0] hdr_q;
   reg [11:0] hdr_d;
   reg [15:0] shift_q;
   reg [15:0] shift_d;
   reg mdio_out_d;
   reg mdio_oe_d;
   reg mii_wr;
   reg [15:0] rd_word;
   reg fef_seen_q;

   wire [4:0] hdr_reg = hdr_q[4:0];
   wire [11:0] hdr_next = {hdr_q[10:0], mdio_in};
   wire addr_hit = (hdr_next[9:5] == PHY_ADDR);
   wire wr_ctrl = mii_wr && (hdr_reg == `PMV_REG_LINE_CONTROL);
   wire wr_adv = mii_wr && (hdr_reg == `PMV_REG_NEG_OFFER);
   wire [15:0] wr_word = {shift_q[14:0], mdio_in};

   // ******************************************************
   // Management clock edge
   // ******************************************************
   pmv_mdc_sense u_mdc_sense (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .mdc(mdc),
      .mdc_rise(mdc_rise)
   );

   // ******************************************************
   // Mirrored control and offer bits
   // ******************************************************
   // Control bits shared with the switch's per-port control byte
   pmv_ctrl_mirror #(
      .WIDTH(4),
      .RESET_VAL(`PMV_CTL_RESET)
   ) u_ctrl (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .mii_wr(wr_ctrl),
      .mii_mask(4'hF),
      .mii_data(wr_word[3:0]),
      .sw_wr(sw_ctrl_wr),
      .sw_mask(4'hF),
      .sw_data({sw_ctrl_wdata[`PMV_SW_MDIX_OFF], sw_ctrl_wdata[`PMV_SW_FEF_OFF],
                sw_ctrl_wdata[`PMV_SW_TX_OFF], sw_ctrl_wdata[`PMV_SW_IND_OFF]}),
      .bits(ctrl_bits)
   );

   // Offer bits plus negotiation enable; enable is not writable from here
   pmv_ctrl_mirror #(
      .WIDTH(6),
      .RESET_VAL(`PMV_ADV_RESET)
   ) u_adv (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .mii_wr(wr_adv),
      .mii_mask(6'h1F),
      .mii_data({1'b0, wr_word[`PMV_ADV_PAUSE], wr_word[`PMV_ADV_100F],
                 wr_word[`PMV_ADV_100H], wr_word[`PMV_ADV_10F], wr_word[`PMV_ADV_10H]}),
      .sw_wr(sw_adv_wr),
      .sw_mask(6'h3F),
      .sw_data({sw_adv_wdata[`PMV_SW_AN_EN], sw_adv_wdata[4:0]}),
      .bits(adv_bits)
   );

   assign mdix_off = ctrl_bits[`PMV_CTL_MDIX_OFF];
   assign fef_detect_off = ctrl_bits[`PMV_CTL_FEF_OFF];
   assign tx_off = ctrl_bits[`PMV_CTL_TX_OFF];
   assign indicator_off = ctrl_bits[`PMV_CTL_IND_OFF];
   assign an_enable = adv_bits[5];
   assign offer_bits = adv_bits[4:0];

   // Switch-side read-back places each bit at its own byte position
   assign sw_ctrl_rdata = {ctrl_bits[`PMV_CTL_IND_OFF], ctrl_bits[`PMV_CTL_TX_OFF], 1'b0,
                           ctrl_bits[`PMV_CTL_FEF_OFF], 1'b0,
                           ctrl_bits[`PMV_CTL_MDIX_OFF], 2'h0};
   assign sw_adv_rdata = {adv_bits[5], 2'h0, adv_bits[4:0]};

   // ******************************************************
   // Line side effects of the control bits
   // ******************************************************
   // Indicators blanked by register, registered to keep the pins glitch free
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         indicator_out <= 3'h0;
      end else begin
         indicator_out <= indicator_off ? 3'h0 : indicator_raw;
      end
   end

   // Fault report only while detection is allowed
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fef_seen_q <= 1'b0;
      end else begin
         fef_seen_q <= far_end_fault & ~fef_detect_off;
      end
   end

   // ******************************************************
   // Read data selection
   // ******************************************************

   // Unsupported and reserved fields are constant zeros
   always @* begin
      rd_word = 16'h0000;
      case (hdr_reg)
         `PMV_REG_LINE_CONTROL: begin
            rd_word[3:0] = ctrl_bits;
         end
         `PMV_REG_LINE_STATUS: begin
            rd_word[15] = 1'b0;
            rd_word[14:11] = `PMV_STS_ABILITY;
            rd_word[10:6] = 5'h00;
            rd_word[`PMV_STS_AN_DONE] = negotiation_done;
            rd_word[`PMV_STS_FEF] = fef_seen_q;
            rd_word[`PMV_STS_AN_CAP] = adv_bits[5];
            rd_word[`PMV_STS_LINK] = link_up;
            rd_word[0] = 1'b0;
         end
         `PMV_REG_IDENT_HIGH: begin
            rd_word = IDENT_UPPER;
         end
         `PMV_REG_IDENT_LOW: begin
            rd_word = IDENT_LOWER;
         end
         `PMV_REG_NEG_OFFER: begin
            rd_word[`PMV_ADV_PAUSE] = adv_bits[4];
            rd_word[`PMV_ADV_100F] = adv_bits[3];
            rd_word[`PMV_ADV_100H] = adv_bits[2];
            rd_word[`PMV_ADV_10F] = adv_bits[1];
            rd_word[`PMV_ADV_10H] = adv_bits[0];
            rd_word[4:0] = `PMV_ADV_SELECTOR;
         end
         `PMV_REG_PARTNER_ABIL: begin
            rd_word[10] = partner_bits[4];
            rd_word[8:5] = partner_bits[3:0];
         end
         default: rd_word = 16'h0000;
      endcase
   end

   // ******************************************************
   // Management frame engine
   // ******************************************************

   // Advances once per rising management clock edge
   always @* begin
      state_d = state_q;
      pre_cnt_d = pre_cnt_q;
      bit_cnt_d = bit_cnt_q;
      hdr_d = hdr_q;
      shift_d = shift_q;
      mdio_out_d = mdio_out;
      mdio_oe_d = mdio_oe;
      mii_wr = 1'b0;
      if (mdc_rise) begin
         case (state_q)
            ST_IDLE: begin
               if (mdio_in) begin
                  if (pre_cnt_q != `PMV_PREAMBLE_ONES) begin
                     pre_cnt_d = pre_cnt_q + 6'h01;
                  end
               end else if (pre_cnt_q == `PMV_PREAMBLE_ONES) begin
                  state_d = ST_START;
               end else begin
                  pre_cnt_d = 6'h00;
               end
            end
            ST_START: begin
               pre_cnt_d = 6'h00;
               bit_cnt_d = 5'h00;
               state_d = mdio_in ? ST_HDR : ST_IDLE;
            end
            ST_HDR: begin
               hdr_d = hdr_next;
               bit_cnt_d = bit_cnt_q + 5'h01;
               if (bit_cnt_q == {1'b0, `PMV_HDR_BITS} - 5'h01) begin
                  bit_cnt_d = 5'h00;
                  // Frames for the other transceiver are timed out, not answered
                  if (addr_hit && hdr_next[11:10] == `PMV_OP_READ) begin
                     state_d = ST_RD_TA;
                  end else if (addr_hit && hdr_next[11:10] == `PMV_OP_WRITE) begin
                     state_d = ST_WR_TA;
                  end else begin
                     state_d = ST_SKIP;
                  end
               end
            end
            ST_RD_TA: begin
               // Second turnaround bit: take the line and drive zero
               mdio_oe_d = 1'b1;
               mdio_out_d = 1'b0;
               shift_d = rd_word;
               bit_cnt_d = 5'h00;
               state_d = ST_RD_DATA;
            end
            ST_RD_DATA: begin
               if (bit_cnt_q == `PMV_DATA_BITS) begin
                  mdio_oe_d = 1'b0;
                  mdio_out_d = 1'b0;
                  state_d = ST_IDLE;
               end else begin
                  mdio_out_d = shift_q[15];
                  shift_d = {shift_q[14:0], 1'b0};
                  bit_cnt_d = bit_cnt_q + 5'h01;
               end
            end
            ST_WR_TA: begin
               bit_cnt_d = bit_cnt_q + 5'h01;
               if (bit_cnt_q == 5'h01) begin
                  bit_cnt_d = 5'h00;
                  state_d = ST_WR_DATA;
               end
            end
            ST_WR_DATA: begin
               shift_d = wr_word;
               bit_cnt_d = bit_cnt_q + 5'h01;
               if (bit_cnt_q == `PMV_DATA_BITS - 5'h01) begin
                  // Only control and offer words take writes
                  mii_wr = 1'b1;
                  state_d = ST_IDLE;
               end
            end
            ST_SKIP: begin
               bit_cnt_d = bit_cnt_q + 5'h01;
               if (bit_cnt_q == `PMV_SKIP_BITS - 5'h01) begin
                  state_d = ST_IDLE;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // Frame engine registers
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         pre_cnt_q <= 6'h00;
         bit_cnt_q <= 5'h00;
         hdr_q <= 12'h000;
         shift_q <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else begin
         state_q <= state_d;
         pre_cnt_q <= pre_cnt_d;
         bit_cnt_q <= bit_cnt_d;
         hdr_q <= hdr_d;
         shift_q <= shift_d;
         mdio_out <= mdio_out_d;
         mdio_oe <= mdio_oe_d;
      end
   end

endmodule // pmv_phy_regs

`default_nettype wire

// *** testbench/pmv_phy_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// *****
// Port relations of the register view
// *****
module pmv_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sw_ctrl_wr,
   input wire logic [7:0] sw_ctrl_wdata,
   input wire logic [7:0] sw_ctrl_rdata,
   input wire logic sw_adv_wr,
   input wire logic [7:0] sw_adv_wdata,
   input wire logic [7:0] sw_adv_rdata,
   input wire logic [2:0] indicator_raw,
   input wire logic [2:0] indicator_out,
   input wire logic mdix_off,
   input wire logic fef_detect_off,
   input wire logic tx_off,
   input wire logic indicator_off,
   input wire logic an_enable,
   input wire logic [4:0] offer_bits,
   input wire logic mdio_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Outputs against their causes
   ind_dark_a: assert property (rst_n && indicator_off |=> indicator_out == 3'h0)
      else $error("indicator lit while turned off");
   ind_pass_a: assert property (rst_n && !indicator_off |=> indicator_out == $past(indicator_raw))
      else $error("indicator not following drive");
   ctl_map_a: assert property (rst_n && sw_ctrl_wr |=> sw_ctrl_rdata == ($past(sw_ctrl_wdata) & 8'hD4))
      else $error("switch control write lost");
   ctl_view_a: assert property (sw_ctrl_rdata == {indicator_off, tx_off, 1'b0, fef_detect_off, 1'b0, mdix_off, 2'h0})
      else $error("control views disagree");
   adv_view_a: assert property (sw_adv_rdata == {an_enable, 2'h0, offer_bits})
      else $error("offer views disagree");
   adv_write_a: assert property (rst_n && sw_adv_wr |=> {an_enable, offer_bits} == {$past(sw_adv_wdata[7]), $past(sw_adv_wdata[4:0])})
      else $error("switch offer write lost");
   an_hold_a: assert property (rst_n && !sw_adv_wr |=> $stable(an_enable))
      else $error("negotiation enable moved without write");
   reset_vals_a: assert property ($rose(rst_n) |-> offer_bits == 5'h1F && an_enable && !mdix_off && !fef_detect_off && !tx_off && !indicator_off)
      else $error("wrong value after reset");
   cover property (sw_ctrl_wr);
   cover property ($rose(mdio_oe));
   cover property (indicator_off);
endmodule // pmv_checker

bind pmv_phy_regs pmv_checker pmv_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .sw_ctrl_wr(sw_ctrl_wr), .sw_ctrl_wdata(sw_ctrl_wdata), .sw_ctrl_rdata(sw_ctrl_rdata),
   .sw_adv_wr(sw_adv_wr), .sw_adv_wdata(sw_adv_wdata), .sw_adv_rdata(sw_adv_rdata),
   .indicator_raw(indicator_raw), .indicator_out(indicator_out), .mdix_off(mdix_off),
   .fef_detect_off(fef_detect_off), .tx_off(tx_off), .indicator_off(indicator_off),
   .an_enable(an_enable), .offer_bits(offer_bits), .mdio_oe(mdio_oe));
`default_nettype wire

// *** testbench/pmv_mdio_station.sv ***
`timescale 1ns/1ps
`default_nettype none
// *****
// Management station model
// *****
module pmv_mdio_station (
   input wire logic clk_sys,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output var logic mdc,
   output wire logic mdio_line
);
   logic st_oe_q = 1'b0;
   logic st_bit_q = 1'b1;
   initial mdc = 1'b0;
   // Released line floats to the pull-up, never the last bit
   assign mdio_line = st_oe_q ? st_bit_q : (mdio_oe ? mdio_out : 1'b1);
   // One frame; clock stands low between frames, 2 high and 2 low cycles a bit
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd, output logic ta_low);
      logic [63:0] w;
      w = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
      rd = 16'h0000;
      ta_low = 1'b0;
      for (int i = 0; i < 65; i++) begin
         @(posedge clk_sys);
         mdc <= 1'b0;
         st_oe_q <= (i < 64) && !(op == 2'h2 && i > 45);
         st_bit_q <= (i < 64) ? w[63 - i] : 1'b1;
         @(posedge clk_sys);
         @(posedge clk_sys);
         mdc <= 1'b1;
         @(posedge clk_sys);
         // Device output seen here was launched at the previous rise
         if (i == 47) ta_low = ~mdio_line;
         if (i > 47 && i < 64) rd = {rd[14:0], mdio_line};
      end
      @(posedge clk_sys);
      mdc <= 1'b0;
   endtask
endmodule // pmv_mdio_station
`default_nettype wire

// *** testbench/phy_mgmt_register_view_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmv_defines.vh"
module phy_mgmt_register_view_test;
   localparam logic [15:0] ID_HI = 16'hA5C3; // Arbitrary value
   localparam logic [15:0] ID_LO = 16'h3C5A; // Arbitrary value
   localparam logic [31:0] SWB = 32'h04104080; // Switch byte per control bit, bit 0 first
   logic clk_sys, rst_n, sw_ctrl_wr, sw_adv_wr, negotiation_done, link_up, far_end_fault;
   logic [7:0] sw_ctrl_wdata, sw_adv_wdata;
   logic [2:0] indicator_raw;
   wire logic mdc, mdio_line, mdio_out, mdio_oe, mdix_off, fef_detect_off, tx_off;
   wire logic indicator_off, an_enable;
   wire logic [7:0] sw_ctrl_rdata, sw_adv_rdata;
   wire logic [2:0] indicator_out;
   wire logic [4:0] offer_bits;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   pmv_phy_regs #(.PHY_ADDR(5'h01), .IDENT_UPPER(ID_HI), .IDENT_LOWER(ID_LO)) pmv_phy_regs_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_line),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .sw_ctrl_wr(sw_ctrl_wr),
      .sw_ctrl_wdata(sw_ctrl_wdata), .sw_ctrl_rdata(sw_ctrl_rdata), .sw_adv_wr(sw_adv_wr),
      .sw_adv_wdata(sw_adv_wdata), .sw_adv_rdata(sw_adv_rdata),
      .negotiation_done(negotiation_done), .link_up(link_up), .far_end_fault(far_end_fault),
      .partner_bits(5'h15), .indicator_raw(indicator_raw), .indicator_out(indicator_out),
      .mdix_off(mdix_off), .fef_detect_off(fef_detect_off), .tx_off(tx_off),
      .indicator_off(indicator_off), .an_enable(an_enable), .offer_bits(offer_bits));
   pmv_mdio_station pmv_mdio_station_inst (.clk_sys(clk_sys), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .mdc(mdc), .mdio_line(mdio_line));
   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Read through the station; turnaround low only when this device answers
   task automatic mrd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] v;
      logic t;
      pmv_mdio_station_inst.frame(`PMV_OP_READ, phy, ra, 16'h0000, v, t);
      check("read word", v, exp);
      check("turnaround", {15'h0, t}, {15'h0, phy == 5'h01});
   endtask
   task automatic mwr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] v;
      logic t;
      pmv_mdio_station_inst.frame(`PMV_OP_WRITE, phy, ra, d, v, t);
   endtask
   // Switch-side byte write, one cycle pulse
   task automatic sw_put(input logic adv, input logic [7:0] d);
      @(posedge clk_sys);
      sw_ctrl_wr <= !adv;
      sw_adv_wr <= adv;
      sw_ctrl_wdata <= d;
      sw_adv_wdata <= d;
      @(posedge clk_sys);
      sw_ctrl_wr <= 1'b0;
      sw_adv_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Hang guard, about three and a half times the expected run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {sw_ctrl_wr, sw_adv_wr, negotiation_done, link_up, far_end_fault} = 5'h00;
      sw_ctrl_wdata = 8'h00;
      sw_adv_wdata = 8'h00;
      indicator_raw = 3'h5;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      mrd(5'h01, `PMV_REG_LINE_CONTROL, 16'h0000);
      mrd(5'h01, `PMV_REG_LINE_STATUS, 16'h7808);
      mrd(5'h01, `PMV_REG_IDENT_HIGH, ID_HI);
      mrd(5'h01, `PMV_REG_IDENT_LOW, ID_LO);
      mrd(5'h01, `PMV_REG_NEG_OFFER, 16'h05E1);
      mrd(5'h01, `PMV_REG_PARTNER_ABIL, 16'h04A0);
      negotiation_done <= 1'b1;
      link_up <= 1'b1;
      far_end_fault <= 1'b1;
      mrd(5'h01, `PMV_REG_LINE_STATUS, 16'h783C);
      mwr(5'h01, `PMV_REG_LINE_STATUS, 16'h0000);
      mrd(5'h01, `PMV_REG_LINE_STATUS, 16'h783C);
      // Each control bit alone, seen on both views and at the ports
      for (int k = 0; k < 4; k++) begin
         mwr(5'h01, `PMV_REG_LINE_CONTROL, 16'h0001 << k);
         mrd(5'h01, `PMV_REG_LINE_CONTROL, 16'h0001 << k);
         check("ctl pins", {12'h0, mdix_off, fef_detect_off, tx_off, indicator_off}, 16'h1 << k);
         check("sw ctl", {8'h0, sw_ctrl_rdata}, {8'h0, SWB[8*k +: 8]});
         check("ind out", {13'h0, indicator_out}, (k == 0) ? 16'h0 : 16'h5);
      end
      mwr(5'h01, `PMV_REG_LINE_CONTROL, 16'h0004);
      mrd(5'h01, `PMV_REG_LINE_STATUS, 16'h782C);
      mwr(5'h01, `PMV_REG_LINE_CONTROL, 16'hFFFF);
      mrd(5'h01, `PMV_REG_LINE_CONTROL, 16'h000F);
      sw_put(1'b0, 8'h00);
      mrd(5'h01, `PMV_REG_LINE_CONTROL, 16'h0000);
      sw_put(1'b0, 8'hD4);
      mrd(5'h01, `PMV_REG_LINE_CONTROL, 16'h000F);
      // Offer through the switch side, then from the station
      sw_put(1'b1, 8'h00);
      mrd(5'h01, `PMV_REG_LINE_STATUS, 16'h7824);
      mrd(5'h01, `PMV_REG_NEG_OFFER, 16'h0001);
      mwr(5'h01, `PMV_REG_NEG_OFFER, 16'hFFFF);
      mrd(5'h01, `PMV_REG_NEG_OFFER, 16'h05E1);
      check("sw adv", {8'h0, sw_adv_rdata}, 16'h001F);
      mwr(5'h01, `PMV_REG_NEG_OFFER, 16'h0420);
      check("offer pins", {11'h0, offer_bits}, 16'h0011);
      mwr(5'h01, `PMV_REG_IDENT_HIGH, 16'h0000);
      mrd(5'h01, `PMV_REG_IDENT_HIGH, ID_HI);
      // Frames for the other transceiver must pass unanswered
      mrd(5'h02, `PMV_REG_IDENT_LOW, 16'hFFFF);
      mwr(5'h02, `PMV_REG_NEG_OFFER, 16'hFFFF);
      mrd(5'h01, `PMV_REG_NEG_OFFER, 16'h0421);
      close_out();
   end
endmodule // phy_mgmt_register_view_test
`default_nettype wire
